//--- verilog/rmp_params.svh
// Constants for the reset and mode-select pin controller.
// Summary of operation
// (R01) Power-on leaves reset pin as port pin.
// (R02) Enable bit makes sticky open-drain reset pin.
// (R03) External low on enabled pin resets device.
// (R04) Non-POR reset drives pin low 66 cycles.
// (R05) Reset cause recorded in status register.
// (R06) Pin reset always user; force needs mode-select.
// (R07) Mode-select input during POR or force reset.
// (R08) Pin is debug pin right after reset.
// (R09) Pull-up on while background enable is one.
// (R10) Background enable set by every reset.
// (R11) Mode-select high gives normal mode at release.
// (R12) Mode-select held low gives background mode.
// (R13) Each debug bit lasts 16 clock cycles.
// (R14) Brief driven-high speed-up pulses on debug pin.
// (R15) Internal clock source selected after reset.
`ifndef RMP_PARAMS_SVH
`define RMP_PARAMS_SVH
// Register byte offsets.
`define RMP_OFS_SYS_OPTS 8'h00
`define RMP_OFS_RST_CAUSE 8'h04
`define RMP_OFS_FORCE 8'h08
`define RMP_OFS_IRQ_STATUS 8'h0c
`define RMP_OFS_IRQ_MASK 8'h10
`define RMP_OFS_MODE 8'h14
// Field positions in system_options_one.
`define RMP_BIT_RESET_PIN_ENABLE 0
`define RMP_BIT_BKGDEN 1
`define RMP_BIT_CLKEXT 2
// Field positions in reset_cause_status.
`define RMP_BIT_C_POR 0
`define RMP_BIT_C_PIN 1
`define RMP_BIT_C_INT 2
`define RMP_BIT_C_FORCE 3
// Field positions in the interrupt status and mask.
`define RMP_BIT_I_PIN 0
`define RMP_BIT_I_INT 1
`define RMP_BIT_I_FORCE 2
`define RMP_BIT_I_BDC 3
// Field position of the force bit in debug_force_reset_register.
`define RMP_BIT_FORCE 0
// Field positions in the mode register.
`define RMP_BIT_M_BDM 0
`define RMP_BIT_M_RST 1
// Reset values.
`define RMP_RST_IRQ_MASK 4'h0
`define RMP_RST_CAUSE_POR 4'h1
// Timing counts in bus clock cycles.
`define RMP_DRIVE_CYC 66
`define RMP_POR_CYC 4
`define RMP_SETTLE_CYC 4
`define RMP_BIT_CYC 16
`define RMP_LOW_CYC 4
`define RMP_ZERO_CYC 12
`endif

//--- verilog/rmp_pkg.sv
// Types shared by the reset and mode-select pin controller.
package rmp_pkg;
  // Reset sequencer states.
  typedef enum logic [1:0] {
    RMP_POR = 2'b00,
    RMP_RUN = 2'b01,
    RMP_DRIVE = 2'b10,
    RMP_SETTLE = 2'b11
  } rmp_seq_e;
  // Kind of the non power-on reset in progress.
  typedef enum logic [1:0] {
    RMP_C_PIN = 2'b00,
    RMP_C_INT = 2'b01,
    RMP_C_FORCE = 2'b10
  } rmp_cause_e;
  // Whole state of the controller.
  typedef struct packed {
    rmp_seq_e seq;
    logic [7:0] cnt;
    rmp_cause_e cause;
    logic reset_pin_enable;
    logic background_debug_pin_en;
    logic clk_ext;
    logic active_background_mode;
    logic [3:0] rcs;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic ack;
    logic [31:0] rdat;
    logic rst_s1;
    logic rst_s2;
    logic ms_s1;
    logic ms_s2;
    logic tx_busy;
    logic tx_bit;
    logic [3:0] tx_cnt;
  } rmp_state_s;
endpackage : rmp_pkg

//--- verilog/rmp_ctrl.sv
// Reset pin, mode-select pin and debug pin controller with Wishbone registers.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "rmp_params.svh"
module rmp_ctrl (
  // Clock and power-on reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Reset requests from the rest of the chip and the debug controller.
  input wire logic int_rst_req_i,
  input wire logic bdc_cmd_active_i,
  // Reset-capable shared pin.
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n_o,
  output logic rst_pullup_o,
  // Port function of the reset-capable pin.
  input wire logic port_a_bit_five_i,
  input wire logic port_a_bit_five_drive_i,
  // Background debug and mode-select shared pin.
  input wire logic background_debug_pin_pin_i,
  output logic background_debug_pin_pin_o,
  output logic background_debug_pin_pin_oe_n_o,
  output logic background_debug_pin_pullup_o,
  output logic background_debug_pin_rx_o,
  // Alternate port or comparator function of the debug pin.
  input wire logic alt_out_i,
  input wire logic alt_drive_i,
  // Debug bit transmitter.
  input wire logic bdc_tx_valid_i,
  input wire logic bdc_tx_bit_i,
  output logic bdc_tx_ready_o,
  // System outputs.
  output logic core_rst_o,
  output logic bdm_o,
  output logic int_clk_sel_o,
  output logic irq_o
);

  // State held in one register, next value built in one process.
  rmp_pkg::rmp_state_s s;
  rmp_pkg::rmp_state_s next_s;
  // Bus request in its first cycle.
  logic bus_hit;
  // Bus write at the acknowledging edge.
  logic bus_wr;
  // Accepted debug force reset request.
  logic force_req;
  // Interrupt events and clears for this cycle.
  logic [3:0] irq_set;
  logic [3:0] irq_clr;

  // Power-on state: port pin, debug pin enabled, internal clock, hold.
  localparam rmp_pkg::rmp_state_s RMP_RST_STATE = '{
    seq: rmp_pkg::RMP_POR, cnt: 8'h00, cause: rmp_pkg::RMP_C_PIN,
    reset_pin_enable: 1'b0, background_debug_pin_en: 1'b1, clk_ext: 1'b0, active_background_mode: 1'b0,
    rcs: `RMP_RST_CAUSE_POR, irq_st: 4'h0, irq_mask: `RMP_RST_IRQ_MASK,
    ack: 1'b0, rdat: 32'h0000_0000, rst_s1: 1'b1, rst_s2: 1'b1,
    ms_s1: 1'b1, ms_s2: 1'b1, tx_busy: 1'b0, tx_bit: 1'b0,
    tx_cnt: 4'h0};

  // Compares the word address of the bus against a register offset.
  function automatic logic reg_at(input logic [7:0] adr,
                                  input logic [7:0] ofs);
    reg_at = (adr[7:2] == ofs[7:2]);
  endfunction

  // Transmitter may take a new bit only while running with the pin enabled.
  assign bdc_tx_ready_o = (s.seq == rmp_pkg::RMP_RUN) && s.background_debug_pin_en &&
                          !s.tx_busy;

  // Next-state logic for the bus, the sequencer and the transmitter.
  always_comb begin
    next_s = s;
    irq_set = 4'h0;
    irq_clr = 4'h0;
    bus_hit = wb_cyc_i && wb_stb_i && !s.ack;
    bus_wr = wb_cyc_i && wb_stb_i && s.ack && wb_we_i && wb_sel_i[0];
    // Both pins pass two flip-flops before anything looks at them.
    next_s.rst_s1 = rst_pin_i;
    next_s.rst_s2 = s.rst_s1;
    next_s.ms_s1 = background_debug_pin_pin_i;
    next_s.ms_s2 = s.ms_s1;
    // Every access is answered one cycle later, unmapped ones with zero.
    next_s.ack = bus_hit;
    if (bus_hit) begin
      next_s.rdat = 32'h0000_0000;
      if (reg_at(wb_adr_i, `RMP_OFS_SYS_OPTS)) begin
        next_s.rdat[`RMP_BIT_RESET_PIN_ENABLE] = s.reset_pin_enable;
        next_s.rdat[`RMP_BIT_BKGDEN] = s.background_debug_pin_en;
        next_s.rdat[`RMP_BIT_CLKEXT] = s.clk_ext;
      end else if (reg_at(wb_adr_i, `RMP_OFS_RST_CAUSE)) begin
        next_s.rdat[3:0] = s.rcs;
      end else if (reg_at(wb_adr_i, `RMP_OFS_IRQ_STATUS)) begin
        next_s.rdat[3:0] = s.irq_st;
      end else if (reg_at(wb_adr_i, `RMP_OFS_IRQ_MASK)) begin
        next_s.rdat[3:0] = s.irq_mask;
      end else if (reg_at(wb_adr_i, `RMP_OFS_MODE)) begin
        next_s.rdat[`RMP_BIT_M_BDM] = s.active_background_mode;
        next_s.rdat[`RMP_BIT_M_RST] = (s.seq != rmp_pkg::RMP_RUN);
      end
    end
    // Writes take effect at the edge where the master sees ack.
    if (bus_wr && reg_at(wb_adr_i, `RMP_OFS_SYS_OPTS)) begin
      // Once set, only power-on clears the enable, so a zero is ignored.
      if (wb_dat_i[`RMP_BIT_RESET_PIN_ENABLE]) begin
        next_s.reset_pin_enable = 1'b1; // R02
      end
      next_s.background_debug_pin_en = wb_dat_i[`RMP_BIT_BKGDEN]; // R10
      next_s.clk_ext = wb_dat_i[`RMP_BIT_CLKEXT];
    end
    if (bus_wr && reg_at(wb_adr_i, `RMP_OFS_IRQ_STATUS)) begin
      irq_clr = wb_dat_i[3:0];
    end
    if (bus_wr && reg_at(wb_adr_i, `RMP_OFS_IRQ_MASK)) begin
      next_s.irq_mask = wb_dat_i[3:0];
    end
    // Force is honoured only behind an active background command.
    force_req = bus_wr && reg_at(wb_adr_i, `RMP_OFS_FORCE) &&
                wb_dat_i[`RMP_BIT_FORCE] && bdc_cmd_active_i; // R06
    // Reset sequencer.
    unique case (s.seq)
      rmp_pkg::RMP_POR: begin
        if (s.cnt == 8'(`RMP_POR_CYC - 1)) begin
          next_s.seq = rmp_pkg::RMP_RUN;
          next_s.cnt = 8'h00;
          // Mode-select sampled at the release of power-on reset.
          next_s.active_background_mode = !s.ms_s2; // R07 R11 R12
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      rmp_pkg::RMP_RUN: begin
        // Pin reset wins over internal, internal over force.
        if (s.reset_pin_enable && !s.rst_s2) begin
          next_s.seq = rmp_pkg::RMP_DRIVE; // R03
          next_s.cause = rmp_pkg::RMP_C_PIN;
          irq_set[`RMP_BIT_I_PIN] = 1'b1;
        end else if (int_rst_req_i) begin
          next_s.seq = rmp_pkg::RMP_DRIVE;
          next_s.cause = rmp_pkg::RMP_C_INT;
          irq_set[`RMP_BIT_I_INT] = 1'b1;
        end else if (force_req) begin
          next_s.seq = rmp_pkg::RMP_DRIVE;
          next_s.cause = rmp_pkg::RMP_C_FORCE;
          irq_set[`RMP_BIT_I_FORCE] = 1'b1;
        end
        next_s.cnt = 8'h00;
      end
      rmp_pkg::RMP_DRIVE: begin
        if (s.cnt == 8'(`RMP_DRIVE_CYC - 1)) begin // R04
          next_s.seq = rmp_pkg::RMP_SETTLE;
          next_s.cnt = 8'h00;
          next_s.background_debug_pin_en = 1'b1; // R08 R10
          next_s.clk_ext = 1'b0; // R15
          next_s.tx_busy = 1'b0;
          next_s.rcs = 4'h0;
          // Only one cause flag stands after each reset.
          unique case (s.cause)
            rmp_pkg::RMP_C_PIN: next_s.rcs[`RMP_BIT_C_PIN] = 1'b1; // R05
            rmp_pkg::RMP_C_INT: next_s.rcs[`RMP_BIT_C_INT] = 1'b1;
            rmp_pkg::RMP_C_FORCE: next_s.rcs[`RMP_BIT_C_FORCE] = 1'b1;
            default: next_s.rcs[`RMP_BIT_C_INT] = 1'b1;
          endcase
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      rmp_pkg::RMP_SETTLE: begin
        // The wait lets the released pin climb back through the syncs.
        if (s.cnt == 8'(`RMP_SETTLE_CYC - 1)) begin
          next_s.seq = rmp_pkg::RMP_RUN;
          next_s.cnt = 8'h00;
          // Only a force reset looks at mode-select; pin resets go user.
          next_s.active_background_mode = (s.cause == rmp_pkg::RMP_C_FORCE) &&
                       !s.ms_s2; // R06 R11 R12
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
    endcase
    // Debug bit transmitter, one bit cell per 16 clock cycles.
    if (bdc_tx_ready_o && bdc_tx_valid_i) begin
      next_s.tx_busy = 1'b1;
      next_s.tx_bit = bdc_tx_bit_i;
      next_s.tx_cnt = 4'h0;
    end else if (s.tx_busy && s.seq == rmp_pkg::RMP_RUN) begin
      next_s.tx_cnt = s.tx_cnt + 4'h1;
      if (s.tx_cnt == 4'(`RMP_BIT_CYC - 1)) begin // R13
        next_s.tx_busy = 1'b0;
        irq_set[`RMP_BIT_I_BDC] = 1'b1;
      end
    end
    // A new event beats a clear arriving in the same cycle.
    next_s.irq_st = (s.irq_st & ~irq_clr) | irq_set;
  end

  // State register; power-on reset loads the constant state.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= RMP_RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  // Reset pin: port pin until enabled, then open-drain reset output.
  always_comb begin
    if (s.reset_pin_enable) begin
      rst_pin_o = 1'b0;
      rst_pin_oe_n_o = (s.seq != rmp_pkg::RMP_DRIVE); // R04
    end else begin
      rst_pin_o = port_a_bit_five_i; // R01
      rst_pin_oe_n_o = !port_a_bit_five_drive_i;
    end
  end

  // Debug pin: pseudo open-drain with a driven high pulse to speed edges.
  always_comb begin
    background_debug_pin_pin_o = 1'b0;
    background_debug_pin_pin_oe_n_o = 1'b1;
    if (!s.background_debug_pin_en) begin
      background_debug_pin_pin_o = alt_out_i;
      background_debug_pin_pin_oe_n_o = !alt_drive_i;
    end else if (s.tx_busy && s.seq == rmp_pkg::RMP_RUN) begin
      // A one ends its low phase early; a zero holds it longer.
      if (s.tx_cnt < 4'(`RMP_LOW_CYC)) begin
        background_debug_pin_pin_oe_n_o = 1'b0;
      end else if (s.tx_bit && s.tx_cnt == 4'(`RMP_LOW_CYC)) begin
        background_debug_pin_pin_o = 1'b1; // R14
        background_debug_pin_pin_oe_n_o = 1'b0;
      end else if (!s.tx_bit && s.tx_cnt < 4'(`RMP_ZERO_CYC)) begin
        background_debug_pin_pin_oe_n_o = 1'b0;
      end else if (!s.tx_bit && s.tx_cnt == 4'(`RMP_ZERO_CYC)) begin
        background_debug_pin_pin_o = 1'b1; // R14
        background_debug_pin_pin_oe_n_o = 1'b0;
      end
    end
  end

  // Plain outputs decoded from the state register.
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign rst_pullup_o = s.reset_pin_enable; // R02
  assign background_debug_pin_pullup_o = s.background_debug_pin_en; // R09
  assign background_debug_pin_rx_o = s.ms_s2;
  assign core_rst_o = (s.seq != rmp_pkg::RMP_RUN);
  assign bdm_o = s.active_background_mode;
  assign int_clk_sel_o = !s.clk_ext; // R15
  assign irq_o = |(s.irq_st & s.irq_mask);

  // Helper that counts consecutive cycles of driven-low reset pin.
  logic [7:0] drv_len;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drv_len <= 8'h00;
    end else if (s.reset_pin_enable && !rst_pin_oe_n_o) begin
      drv_len <= drv_len + 8'h01;
    end else begin
      drv_len <= 8'h00;
    end
  end

  // Steps of a pin-triggered reset.
  sequence s_pin_low_seen;
    s.seq == rmp_pkg::RMP_RUN && s.reset_pin_enable && !s.rst_s2;
  endsequence
  sequence s_drive_entered;
    s.seq == rmp_pkg::RMP_DRIVE && s.cause == rmp_pkg::RMP_C_PIN;
  endsequence

  property p_port_pin;
    @(posedge clk_i) disable iff (sys_rst_i)
    !s.reset_pin_enable |-> rst_pin_oe_n_o == !port_a_bit_five_drive_i;
  endproperty
  a_port_pin: assert property (p_port_pin) // R01
    else $error("reset pin not a port pin while disabled");

  property p_reset_pin_enable_sticky;
    @(posedge clk_i) disable iff (sys_rst_i)
    $past(s.reset_pin_enable) |-> s.reset_pin_enable && rst_pullup_o;
  endproperty
  a_reset_pin_enable_sticky: assert property (p_reset_pin_enable_sticky) // R02
    else $error("reset pin enable lost before power-on");

  property p_pin_reset;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_pin_low_seen |=> s_drive_entered ##1 core_rst_o;
  endproperty
  a_pin_reset: assert property (p_pin_reset) // R03
    else $error("external low on reset pin did not reset");

  property p_drive_len;
    @(posedge clk_i) disable iff (sys_rst_i)
    // The enable turning on also lifts the enable; only a drive that ends
    // while the pin was already enabled counts.
    (s.reset_pin_enable && $past(s.reset_pin_enable) && $rose(rst_pin_oe_n_o)) |->
      drv_len == 8'h42;
  endproperty
  a_drive_len: assert property (p_drive_len) // R04
    else $error("reset pin low time is not 66 cycles");

  property p_cause;
    @(posedge clk_i) disable iff (sys_rst_i)
    (s.seq == rmp_pkg::RMP_DRIVE && s.cause == rmp_pkg::RMP_C_PIN &&
     s.cnt == 8'd65) |=> s.rcs == 4'h2;
  endproperty
  a_cause: assert property (p_cause) // R05
    else $error("pin reset cause not recorded");

  property p_pin_user;
    @(posedge clk_i) disable iff (sys_rst_i)
    (s.seq == rmp_pkg::RMP_SETTLE && s.cause != rmp_pkg::RMP_C_FORCE)
      ##1 !core_rst_o |-> !bdm_o;
  endproperty
  a_pin_user: assert property (p_pin_user) // R06
    else $error("non-force reset entered background mode");

  property p_ms_input;
    @(posedge clk_i) disable iff (sys_rst_i)
    (core_rst_o && s.background_debug_pin_en) |-> background_debug_pin_pin_oe_n_o;
  endproperty
  a_ms_input: assert property (p_ms_input) // R07
    else $error("mode-select pin driven during reset");

  property p_after_reset;
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(core_rst_o) |-> s.background_debug_pin_en && background_debug_pin_pullup_o && int_clk_sel_o;
  endproperty
  a_after_reset: assert property (p_after_reset) // R08 R09 R10 R15
    else $error("debug pin or clock wrong after reset");

  property p_force_mode;
    @(posedge clk_i) disable iff (sys_rst_i)
    (s.seq == rmp_pkg::RMP_SETTLE && s.cause == rmp_pkg::RMP_C_FORCE &&
     s.cnt == 8'd3) |=> bdm_o == !$past(s.ms_s2);
  endproperty
  a_force_mode: assert property (p_force_mode) // R11 R12
    else $error("force reset mode does not follow mode-select");

  property p_bit_len;
    @(posedge clk_i) disable iff (sys_rst_i)
    (bdc_tx_ready_o && bdc_tx_valid_i) |=>
      s.tx_busy [*8] ##1 s.tx_busy [*8] ##1 !s.tx_busy;
  endproperty
  a_bit_len: assert property (p_bit_len) // R13
    else $error("debug bit cell is not 16 cycles");

  property p_speedup;
    @(posedge clk_i) disable iff (sys_rst_i)
    (bdc_tx_ready_o && bdc_tx_valid_i && bdc_tx_bit_i) |=>
      ##4 (background_debug_pin_pin_o && !background_debug_pin_pin_oe_n_o) ##1 background_debug_pin_pin_oe_n_o;
  endproperty
  a_speedup: assert property (p_speedup) // R14
    else $error("missing speed-up pulse on debug pin");

endmodule // rmp_ctrl

//--- testbench/rmp_pod_model.sv
// Board model: external reset source, debug pod and pin pull-ups.
`timescale 1ns/1ps
module rmp_pod_model (
  // Clock.
  input wire logic clk_i,
  // Device pin drivers.
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n_o,
  input wire logic background_debug_pin_pin_o,
  input wire logic background_debug_pin_pin_oe_n_o,
  // Bench controls for the external parties.
  input wire logic ext_low_i,
  input wire logic ms_low_i,
  // Resolved pin levels and pod measurements.
  output logic rst_wire_o,
  output logic background_debug_pin_wire_o,
  output logic [7:0] low_len_o,
  output logic [7:0] hi_drv_o
);
  // Length of the low phase now in progress.
  logic [7:0] low_cnt = 8'h00;
  // The device wins when it drives; otherwise the pull-up holds the pin
  // high unless the reset switch pulls it down.
  assign rst_wire_o = !rst_pin_oe_n_o ? rst_pin_o : !ext_low_i;
  // The pod holds mode-select low only when told to.
  assign background_debug_pin_wire_o = !background_debug_pin_pin_oe_n_o ? background_debug_pin_pin_o : !ms_low_i;
  // Measure each low phase and count actively driven high cycles.
  // A plain always block, because the initial block also sets the outputs.
  always @(posedge clk_i) begin
    if (!background_debug_pin_wire_o) begin
      low_cnt <= low_cnt + 8'h01;
    end else if (low_cnt != 8'h00) begin
      low_len_o <= low_cnt;
      low_cnt <= 8'h00;
    end
    if (!background_debug_pin_pin_oe_n_o && background_debug_pin_pin_o) begin
      hi_drv_o <= hi_drv_o + 8'h01;
    end
  end
  // Counters start from zero at time zero.
  initial begin
    low_len_o = 8'h00;
    hi_drv_o = 8'h00;
  end
endmodule // rmp_pod_model

//--- testbench/rmp_ctrl_tb_top.sv
// Self-checking bench for the reset and mode-select pin controller.
`timescale 1ns/1ps
module rmp_ctrl_tb_top;
  // Clock, reset and bus master signals.
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, wb_dat;
  // Other stimulus; the port driver drives high, the alternate driver drives low.
  logic int_req = 1'b0, cmd_act = 1'b0, tx_v = 1'b0, tx_b = 1'b0;
  logic port_d = 1'b1, port_drv = 1'b1, alt_d = 1'b0, alt_drv = 1'b1;
  logic ext_low = 1'b0, ms_low = 1'b0;
  // Observed outputs.
  logic ack, rst_o, rst_oe_n, rst_pu, bk_o, bk_oe_n, bk_pu, bk_rx;
  logic tx_rdy, core_rst, active_background_mode, clk_sel, irq, rst_w, bk_w;
  logic [7:0] low_len, hi_drv;
  int n_errors = 0;
  int n_compared = 0;
  // Bus clock of 100 ns.
  always #50 clk_i = ~clk_i;
  rmp_ctrl i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(ack),
    .int_rst_req_i(int_req), .bdc_cmd_active_i(cmd_act),
    .rst_pin_i(rst_w), .rst_pin_o(rst_o), .rst_pin_oe_n_o(rst_oe_n),
    .rst_pullup_o(rst_pu), .port_a_bit_five_i(port_d),
    .port_a_bit_five_drive_i(port_drv), .background_debug_pin_pin_i(bk_w),
    .background_debug_pin_pin_o(bk_o), .background_debug_pin_pin_oe_n_o(bk_oe_n), .background_debug_pin_pullup_o(bk_pu),
    .background_debug_pin_rx_o(bk_rx), .alt_out_i(alt_d), .alt_drive_i(alt_drv),
    .bdc_tx_valid_i(tx_v), .bdc_tx_bit_i(tx_b), .bdc_tx_ready_o(tx_rdy),
    .core_rst_o(core_rst), .bdm_o(active_background_mode), .int_clk_sel_o(clk_sel),
    .irq_o(irq));
  rmp_pod_model i_pod (.clk_i(clk_i), .rst_pin_o(rst_o),
    .rst_pin_oe_n_o(rst_oe_n), .background_debug_pin_pin_o(bk_o), .background_debug_pin_pin_oe_n_o(bk_oe_n),
    .ext_low_i(ext_low), .ms_low_i(ms_low), .rst_wire_o(rst_w),
    .background_debug_pin_wire_o(bk_w), .low_len_o(low_len), .hi_drv_o(hi_drv));
  // Compare one value and report a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Print the verdict and stop.
  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One classic Wishbone cycle, entered just after a rising edge.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rdat = wb_dat;
    if (k >= 50) n_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Keeps the strobe low for a cycle before the next request.
    @(posedge clk_i);
  endtask
  // Read one register and compare.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Wait, bounded, until the chip leaves reset.
  task automatic wait_run();
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (core_rst !== 1'b0 && k < 200);
  endtask
  // Power-on reset with the mode-select pin held as asked.
  task automatic por(input logic ms);
    sys_rst_i <= 1'b1;
    ms_low <= ms;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wait_run();
  endtask
  // Wait for the pin drive, free the switch, count the driven cycles.
  task automatic drive_len(output int n);
    int k;
    k = 0;
    while (rst_oe_n !== 1'b0 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    ext_low <= 1'b0;
    n = 0;
    while (rst_oe_n === 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // Offer one debug bit and count cycles until the sender is ready.
  task automatic send(input logic b, output int n);
    int k;
    k = 0;
    tx_v <= 1'b1;
    tx_b <= b;
    do begin
      @(posedge clk_i);
      k++;
    end while (tx_rdy !== 1'b1 && k < 50);
    tx_v <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tx_rdy !== 1'b1 && n < 40);
  endtask
  // Power-on state, register reset values and mode select.
  task automatic t_por();
    // The state is only known once a clock edge has seen reset high.
    repeat (2) @(posedge clk_i);
    chk(bk_oe_n, 1'b1);
    chk(clk_sel, 1'b1);
    por(1'b0);
    chk(active_background_mode, 1'b0);
    chk(rst_o, 1'b1);
    chk(rst_oe_n, 1'b0);
    chk(rst_pu, 1'b0);
    chk(bk_oe_n, 1'b1);
    chk(bk_pu, 1'b1);
    rd_chk(8'h00, 32'h2);
    rd_chk(8'h04, 32'h1);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h20, 32'h0);
    por(1'b1);
    chk(active_background_mode, 1'b1);
    chk(bk_rx, 1'b0);
    ms_low <= 1'b0;
    rd_chk(8'h14, 32'h1);
    por(1'b0);
  endtask
  // External pin reset, sticky enable and the interrupt path.
  task automatic t_pin();
    int n;
    wb(1'b1, 8'h00, 32'h5);
    wb(1'b1, 8'h00, 32'h4);
    rd_chk(8'h00, 32'h5);
    chk(rst_pu, 1'b1);
    chk(rst_oe_n, 1'b1);
    chk(clk_sel, 1'b0);
    chk(bk_pu, 1'b0);
    ext_low <= 1'b1;
    ms_low <= 1'b1;
    drive_len(n);
    chk(n, 66);
    wait_run();
    chk(active_background_mode, 1'b0);
    ms_low <= 1'b0;
    rd_chk(8'h04, 32'h2);
    rd_chk(8'h00, 32'h3);
    chk(clk_sel, 1'b1);
    chk(irq, 1'b0);
    wb(1'b1, 8'h10, 32'h1);
    chk(irq, 1'b1);
    wb(1'b1, 8'h0c, 32'h1);
    chk(irq, 1'b0);
  endtask
  // Internal reset request.
  task automatic t_int();
    int n;
    int_req <= 1'b1;
    @(posedge clk_i);
    int_req <= 1'b0;
    drive_len(n);
    chk(n, 66);
    wait_run();
    rd_chk(8'h04, 32'h4);
  endtask
  // Debug force reset: gated, then into and out of background mode.
  task automatic t_force();
    int n;
    wb(1'b1, 8'h08, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(core_rst, 1'b0);
    cmd_act <= 1'b1;
    ms_low <= 1'b1;
    wb(1'b1, 8'h08, 32'h1);
    drive_len(n);
    chk(n, 66);
    wait_run();
    chk(active_background_mode, 1'b1);
    ms_low <= 1'b0;
    rd_chk(8'h04, 32'h8);
    rd_chk(8'h08, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    drive_len(n);
    wait_run();
    chk(active_background_mode, 1'b0);
    cmd_act <= 1'b0;
  endtask
  // Debug bit cells, speed-up pulses, then hand-over to the port.
  task automatic t_tx();
    int n;
    wb(1'b1, 8'h0c, 32'hf);
    send(1'b1, n);
    chk(n, 17);
    chk(low_len, 8'h04);
    send(1'b0, n);
    chk(n, 17);
    chk(low_len, 8'h0c);
    chk(hi_drv, 8'h02);
    rd_chk(8'h0c, 32'h8);
    wb(1'b1, 8'h00, 32'h1);
    chk(tx_rdy, 1'b0);
    chk(bk_oe_n, 1'b0);
    chk(bk_o, 1'b0);
    chk(bk_pu, 1'b0);
  endtask
  // Main sequence.
  initial begin
    t_por();
    t_pin();
    t_int();
    t_force();
    t_tx();
    close_out();
  end
  // Watchdog against a hang.
  initial begin
    repeat (6000) @(posedge clk_i);
    n_errors++;
    close_out();
  end
endmodule // rmp_ctrl_tb_top
